// ==== include/vibration_sensor_spi_pkg.sv ====
// Types shared by the vibration sensor serial register block
`include "vibration_sensor_spi_regs_params.svh"

package vibration_sensor_spi_pkg;

  typedef enum {ST_LOAD, ST_RUN} ctrl_state_t;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] payload;
  } frame_t;

  typedef logic [`CFG_COUNT-1:0][15:0] cfg_image_t;

  typedef struct packed {
    logic [15:0] supply;
    logic [15:0] temperature;
    logic [15:0] accel_peak;
    logic [15:0] aux1_peak;
    logic [15:0] aux2_peak;
  } capture_results_t;

  typedef struct packed {
    logic valid;
    logic [15:0] accel;
    logic [15:0] aux1;
    logic [15:0] aux2;
  } sample_set_t;

  typedef struct packed {
    logic upper;
    logic [7:0] value;
  } command_byte_t;

endpackage : vibration_sensor_spi_pkg

// ==== include/vibration_sensor_spi_regs_params.svh ====
// Constants for the vibration sensor serial register block
`ifndef VIBRATION_SENSOR_SPI_REGS_PARAMS_SVH
`define VIBRATION_SENSOR_SPI_REGS_PARAMS_SVH

// Frame shape
`define FRAME_BITS 16
`define FRAME_LAST_BIT 4'hf

// Byte offsets of the lower byte of each register
`define OFS_FLASH_WRITE_COUNT 7'h00
`define OFS_ACCEL_OFFSET_TRIM 7'h02
`define OFS_AUX1_OFFSET_TRIM 7'h04
`define OFS_AUX2_OFFSET_TRIM 7'h06
`define OFS_CAPTURE_SUPPLY_LEVEL 7'h0a
`define OFS_CAPTURE_TEMPERATURE 7'h0c
`define OFS_ACCEL_PEAK_VALUE 7'h0e
`define OFS_AUX1_PEAK_VALUE 7'h10
`define OFS_AUX2_PEAK_VALUE 7'h12
`define OFS_ACCEL_SAMPLE_WINDOW 7'h14
`define OFS_AUX1_SAMPLE_WINDOW 7'h16
`define OFS_AUX2_SAMPLE_WINDOW 7'h18
`define OFS_SAMPLE_INDEX 7'h1a
`define OFS_CAPTURE_CONTROL 7'h1c
`define OFS_CAPTURE_PERIOD 7'h1e
`define OFS_ACCEL_ALARM_THRESHOLD 7'h20
`define OFS_AUX1_ALARM_THRESHOLD 7'h22
`define OFS_AUX2_ALARM_THRESHOLD 7'h24
`define OFS_SYSTEM_ALARM_THRESHOLD 7'h26
`define OFS_ALARM_CONFIG 7'h28
`define OFS_GENERAL_IO_CONFIG 7'h32
`define OFS_MISC_SELFTEST_CONFIG 7'h34
`define OFS_DIGITAL_LINE_CONFIG 7'h36
`define OFS_AVERAGING_CONFIG 7'h38
`define OFS_SYSTEM_STATUS 7'h3c
`define OFS_SYSTEM_COMMAND 7'h3e
`define OFS_SELFTEST_RESPONSE 7'h40
`define OFS_LOT_CODE_LOW 7'h52
`define OFS_LOT_CODE_HIGH 7'h54
`define OFS_PART_IDENTIFIER 7'h56
`define OFS_UNIT_SERIAL_NUMBER 7'h58

// Reset values
`define RST_ZERO 16'h0000
`define RST_CAPTURE_RESULT 16'h8000
`define RST_CAPTURE_CONTROL 16'h0020
`define RST_MISC_SELFTEST_CONFIG 16'h0003
`define RST_DIGITAL_LINE_CONFIG 16'h000f
`define RST_SAMPLE_INDEX 10'h000

// Command bits, as positions inside the upper command byte
`define CMD_CAPTURE_START_BIT 3
`define CMD_FLASH_STORE_BIT 4

// Line function select fields inside digital_line_config
`define DLC_LINE1_LSB 0
`define DLC_LINE2_LSB 2
`define LINE_FN_BUSY 2'h0
`define LINE_FN_ALARM 2'h1
`define LINE_FN_GPIO 2'h2
`define LINE_FN_TRIGGER 2'h3

// Fields of general_io_config used for lines in GPIO function
`define GIO_DIR1_BIT 0
`define GIO_DIR2_BIT 1
`define GIO_LEVEL1_BIT 8
`define GIO_LEVEL2_BIT 9

// Flash-backed configuration slots
`define CFG_COUNT 14
`define SLOT_NONE 4'hf

`endif

// ==== logic/spi_mode3_shifter.sv ====
// Sixteen-bit serial shifter, clock polarity 1 and phase 1
`include "vibration_sensor_spi_regs_params.svh"
module spi_mode3_shifter
  import vibration_sensor_spi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [15:0] tx_word,
  output logic dout,
  output logic dout_oe,
  output logic frame_done,
  output logic [15:0] rx_word
);

  logic sclk_prev;
  logic [3:0] bit_count;
  logic [14:0] rx_shift;
  logic [14:0] tx_shift;
  logic rise;
  logic fall;

  assign rise = !cs_n && !sclk_prev && sclk;
  assign fall = !cs_n && sclk_prev && !sclk;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      bit_count <= 4'h0;
    end else if (rise) begin
      bit_count <= bit_count + 4'h1;
    end
  end

  // Bits taken on the rising edge, most significant first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_shift <= 15'h0000;
      rx_word <= 16'h0000;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (rise) begin
        if (bit_count == `FRAME_LAST_BIT) begin
          rx_word <= {rx_shift, din};
          frame_done <= 1'b1;
        end else begin
          rx_shift <= {rx_shift[13:0], din};
        end
      end
    end
  end

  // Bits driven on the falling edge; word loaded at the first bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout <= 1'b0;
      tx_shift <= 15'h0000;
    end else if (fall) begin
      if (bit_count == 4'h0) begin
        dout <= tx_word[15];
        tx_shift <= tx_word[14:0];
      end else begin
        dout <= tx_shift[14];
        tx_shift <= {tx_shift[13:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= !cs_n;
    end
  end

endmodule : spi_mode3_shifter

// ==== logic/vibration_sensor_spi_regs.sv ====
// Serial register interface of the vibration sensor, device side
//
// Notes on behaviour
// - Mode 3 frames, sixteen bits, MSB first
// - Output shifts out while input shifts in
// - One write frame changes one register byte
// - Capture start pulses right after sixteenth rising edge
// - Read request: flag 0 plus register address
// - Payload byte of read request is ignored
// - Read data returns during the following frame
// - Lower byte even address, upper byte odd
// - Acceleration window read-only, resets to 0x8000
// - Sample index read/write, selects shown samples
// - Part identifier is read-only at 0x56
// - Aux lines: busy, alarm, GPIO or trigger
// - Sample on rising, drive on falling edge
// - Active only with chip select low
// - Flash store command saves backed configuration
// - Reset loads stored configuration before running
`include "vibration_sensor_spi_regs_params.svh"
module vibration_sensor_spi_regs
  import vibration_sensor_spi_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] LOT_CODE_LOW_ID = 16'h0101, // Arbitrary value
  parameter logic [15:0] LOT_CODE_HIGH_ID = 16'h0202, // Arbitrary value
  parameter logic [15:0] SERIAL_ID = 16'h0303 // Arbitrary value
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic aux_digital_line_1_in,
  output logic aux_digital_line_1_out,
  output logic aux_digital_line_1_oe,
  input wire logic aux_digital_line_2_in,
  output logic aux_digital_line_2_out,
  output logic aux_digital_line_2_oe,
  input wire logic capture_busy,
  input wire logic alarm_active,
  input wire logic capture_done,
  input wire capture_results_t capture_results,
  input wire sample_set_t sample_set,
  input wire logic [15:0] flash_write_count,
  input wire logic [15:0] system_status,
  input wire logic [15:0] selftest_response,
  input wire cfg_image_t nv_image,
  output cfg_image_t config_words,
  output logic [9:0] sample_index,
  output logic capture_start,
  output logic capture_trigger,
  output logic nv_store,
  output logic command_pulse,
  output command_byte_t command_byte,
  output logic ready
);

  ctrl_state_t state;
  logic frame_done;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  frame_t frm;
  logic [3:0] slot;
  logic is_write;
  logic is_read;
  logic window_read;
  logic [1:0] line1_fn;
  logic [1:0] line2_fn;

  // Flash-backed configuration slot of a byte address
  function automatic logic [3:0] cfg_slot(input logic [6:0] addr);
    logic [6:0] even;
    even = {addr[6:1], 1'b0};
    unique case (even)
      `OFS_ACCEL_OFFSET_TRIM: cfg_slot = 4'h0;
      `OFS_AUX1_OFFSET_TRIM: cfg_slot = 4'h1;
      `OFS_AUX2_OFFSET_TRIM: cfg_slot = 4'h2;
      `OFS_CAPTURE_CONTROL: cfg_slot = 4'h3;
      `OFS_CAPTURE_PERIOD: cfg_slot = 4'h4;
      `OFS_ACCEL_ALARM_THRESHOLD: cfg_slot = 4'h5;
      `OFS_AUX1_ALARM_THRESHOLD: cfg_slot = 4'h6;
      `OFS_AUX2_ALARM_THRESHOLD: cfg_slot = 4'h7;
      `OFS_SYSTEM_ALARM_THRESHOLD: cfg_slot = 4'h8;
      `OFS_ALARM_CONFIG: cfg_slot = 4'h9;
      `OFS_GENERAL_IO_CONFIG: cfg_slot = 4'ha;
      `OFS_MISC_SELFTEST_CONFIG: cfg_slot = 4'hb;
      `OFS_DIGITAL_LINE_CONFIG: cfg_slot = 4'hc;
      `OFS_AVERAGING_CONFIG: cfg_slot = 4'hd;
      default: cfg_slot = `SLOT_NONE;
    endcase
  endfunction : cfg_slot

  // Reset value of each configuration slot
  function automatic logic [15:0] cfg_default(input int unsigned idx);
    unique case (idx)
      3: cfg_default = `RST_CAPTURE_CONTROL;
      11: cfg_default = `RST_MISC_SELFTEST_CONFIG;
      12: cfg_default = `RST_DIGITAL_LINE_CONFIG;
      default: cfg_default = `RST_ZERO;
    endcase
  endfunction : cfg_default

  // Capture window shows the reset value until a capture has finished
  function automatic logic [15:0] window_word(input logic [15:0] sample);
    window_word = sample_set.valid ? sample : `RST_CAPTURE_RESULT;
  endfunction : window_word

  // Sixteen-bit word returned for a read request
  function automatic logic [15:0] read_word(input logic [6:0] addr);
    logic [6:0] even;
    logic [3:0] s;
    even = {addr[6:1], 1'b0};
    s = cfg_slot(addr);
    if (s != `SLOT_NONE) begin
      read_word = config_words[s];
    end else begin
      unique case (even)
        `OFS_FLASH_WRITE_COUNT: read_word = flash_write_count;
        `OFS_CAPTURE_SUPPLY_LEVEL: read_word = capture_results.supply;
        `OFS_CAPTURE_TEMPERATURE:
          read_word = capture_results.temperature;
        `OFS_ACCEL_PEAK_VALUE: read_word = capture_results.accel_peak;
        `OFS_AUX1_PEAK_VALUE: read_word = capture_results.aux1_peak;
        `OFS_AUX2_PEAK_VALUE: read_word = capture_results.aux2_peak;
        `OFS_ACCEL_SAMPLE_WINDOW:
          read_word = window_word(sample_set.accel);
        `OFS_AUX1_SAMPLE_WINDOW: read_word = window_word(sample_set.aux1);
        `OFS_AUX2_SAMPLE_WINDOW: read_word = window_word(sample_set.aux2);
        `OFS_SAMPLE_INDEX: read_word = {6'h00, sample_index};
        `OFS_SYSTEM_STATUS: read_word = system_status;
        `OFS_SELFTEST_RESPONSE: read_word = selftest_response;
        `OFS_LOT_CODE_LOW: read_word = LOT_CODE_LOW_ID;
        `OFS_LOT_CODE_HIGH: read_word = LOT_CODE_HIGH_ID;
        `OFS_PART_IDENTIFIER: read_word = PART_ID;
        `OFS_UNIT_SERIAL_NUMBER: read_word = SERIAL_ID;
        // Command register is write-only; reserved space reads zero
        default: read_word = `RST_ZERO;
      endcase
    end
  endfunction : read_word

  // Shifting, edge choice and chip select gating live in the shifter
  spi_mode3_shifter u_shifter (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .tx_word(tx_word),
    .dout(dout),
    .dout_oe(dout_oe),
    .frame_done(frame_done),
    .rx_word(rx_word)
  );

  assign frm = frame_t'(rx_word);
  assign slot = cfg_slot(frm.addr);
  assign is_write = frame_done && (state == ST_RUN) && frm.write;
  assign is_read = frame_done && (state == ST_RUN) && !frm.write;
  assign window_read = is_read
    && ({frm.addr[6:1], 1'b0} >= `OFS_ACCEL_SAMPLE_WINDOW)
    && ({frm.addr[6:1], 1'b0} <= `OFS_AUX2_SAMPLE_WINDOW);

  // One cycle after reset the stored image is taken over
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_LOAD;
    end else begin
      unique case (state)
        ST_LOAD: state <= ST_RUN;
        ST_RUN: state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= (state == ST_RUN);
    end
  end

  // Configuration words: reset, stored-image load, single-byte writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `CFG_COUNT; i++) begin
        config_words[i] <= cfg_default(i);
      end
    end else if (state == ST_LOAD) begin
      config_words <= nv_image;
    end else if (is_write && slot != `SLOT_NONE) begin
      if (frm.addr[0]) begin
        config_words[slot][15:8] <= frm.payload;
      end else begin
        config_words[slot][7:0] <= frm.payload;
      end
    end
  end

  // Sample index: cleared by a finished capture, written, auto-advanced
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_index <= `RST_SAMPLE_INDEX;
    end else if (capture_done) begin
      sample_index <= `RST_SAMPLE_INDEX;
    end else if (is_write
      && {frm.addr[6:1], 1'b0} == `OFS_SAMPLE_INDEX) begin
      if (frm.addr[0]) begin
        sample_index[9:8] <= frm.payload[1:0];
      end else begin
        sample_index[7:0] <= frm.payload;
      end
    end else if (window_read) begin
      sample_index <= sample_index + 10'h001;
    end
  end

  // Reply for the next frame; payload byte of a request is not used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_word <= `RST_ZERO;
    end else if (is_read) begin
      tx_word <= read_word(frm.addr);
    end else if (is_write) begin
      tx_word <= `RST_ZERO;
    end
  end

  // Command frames; register writes elsewhere ignore read-only space
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture_start <= 1'b0;
      nv_store <= 1'b0;
      command_pulse <= 1'b0;
      command_byte <= '0;
    end else begin
      capture_start <= 1'b0;
      nv_store <= 1'b0;
      command_pulse <= 1'b0;
      if (is_write && {frm.addr[6:1], 1'b0} == `OFS_SYSTEM_COMMAND) begin
        command_pulse <= 1'b1;
        command_byte <= '{upper: frm.addr[0], value: frm.payload};
        if (frm.addr[0]) begin
          capture_start <= frm.payload[`CMD_CAPTURE_START_BIT];
          nv_store <= frm.payload[`CMD_FLASH_STORE_BIT];
        end
      end
    end
  end

  // Function of each auxiliary line
  assign line1_fn = config_words[12][`DLC_LINE1_LSB +: 2];
  assign line2_fn = config_words[12][`DLC_LINE2_LSB +: 2];

  // Line 1 drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_digital_line_1_out <= 1'b0;
      aux_digital_line_1_oe <= 1'b0;
    end else begin
      unique case (line1_fn)
        `LINE_FN_BUSY: begin
          aux_digital_line_1_out <= capture_busy;
          aux_digital_line_1_oe <= 1'b1;
        end
        `LINE_FN_ALARM: begin
          aux_digital_line_1_out <= alarm_active;
          aux_digital_line_1_oe <= 1'b1;
        end
        `LINE_FN_GPIO: begin
          aux_digital_line_1_out <= config_words[10][`GIO_LEVEL1_BIT];
          aux_digital_line_1_oe <= config_words[10][`GIO_DIR1_BIT];
        end
        `LINE_FN_TRIGGER: begin
          aux_digital_line_1_out <= 1'b0;
          aux_digital_line_1_oe <= 1'b0;
        end
      endcase
    end
  end

  // Line 2 drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_digital_line_2_out <= 1'b0;
      aux_digital_line_2_oe <= 1'b0;
    end else begin
      unique case (line2_fn)
        `LINE_FN_BUSY: begin
          aux_digital_line_2_out <= capture_busy;
          aux_digital_line_2_oe <= 1'b1;
        end
        `LINE_FN_ALARM: begin
          aux_digital_line_2_out <= alarm_active;
          aux_digital_line_2_oe <= 1'b1;
        end
        `LINE_FN_GPIO: begin
          aux_digital_line_2_out <= config_words[10][`GIO_LEVEL2_BIT];
          aux_digital_line_2_oe <= config_words[10][`GIO_DIR2_BIT];
        end
        `LINE_FN_TRIGGER: begin
          aux_digital_line_2_out <= 1'b0;
          aux_digital_line_2_oe <= 1'b0;
        end
      endcase
    end
  end

  // External trigger from any line set as trigger input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture_trigger <= 1'b0;
    end else begin
      capture_trigger <=
        (line1_fn == `LINE_FN_TRIGGER && aux_digital_line_1_in)
        || (line2_fn == `LINE_FN_TRIGGER && aux_digital_line_2_in);
    end
  end

endmodule : vibration_sensor_spi_regs

// ==== verification/spi_host_model.sv ====
// Host master model driving mode 3 sixteen-bit frames
module spi_host_model (
  input wire logic clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 56;
  logic last = 1'b0;
  logic miso;
  // Released line shows the inverse of its last driven level
  always @(posedge clk) if (dout_oe) last <= dout;
  assign miso = dout_oe ? dout : ~last;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input bit keep,
                      output logic [15:0] rx);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      sclk = 1'b0;
      din = tx[i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      rx[i] = miso;
      repeat (HALF - 1) @(negedge clk);
    end
    repeat (HALF) @(negedge clk);
    if (!keep) begin
      cs_n = 1'b1;
      din = ~din;
      repeat (8) @(negedge clk);
    end
  endtask : xfer
endmodule : spi_host_model

// ==== verification/vibration_sensor_spi_regs_asserts.sv ====
// Port-level assertions for the serial register block
module vibration_sensor_spi_regs_asserts
  import vibration_sensor_spi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic capture_done,
  input wire logic [9:0] sample_index,
  input wire logic capture_start,
  input wire logic nv_store,
  input wire logic command_pulse,
  input wire command_byte_t command_byte,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_q;
  logic [3:0] bits;
  logic [14:0] word;
  logic last;
  // Sixteenth rising serial edge of a frame
  assign last = !cs_n && sclk && !sclk_q && bits == 4'hf;
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      bits <= 4'h0;
      word <= 15'h0000;
    end else if (sclk && !sclk_q) begin
      bits <= bits + 4'h1;
      word <= {word[13:0], din};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_on_cmd: assert property (
    last && ready && {word, din} == 16'hbf08 |-> ##[1:3] capture_start)
    else $error("capture start missing after command frame");
  a_store_on_cmd: assert property (
    last && ready && {word, din} == 16'hbf10 |-> ##[1:3] nv_store)
    else $error("store pulse missing after command frame");
  a_start_with_cmd: assert property (
    capture_start |-> command_pulse && command_byte.upper
      && command_byte.value[3])
    else $error("capture start without its command byte");
  a_start_one_cycle: assert property (
    capture_start |=> !capture_start)
    else $error("capture start longer than one cycle");
  a_oe_follows_cs: assert property (
    $past(rst_n) |-> dout_oe == !$past(cs_n))
    else $error("output enable does not follow chip select");
  a_dout_on_fall: assert property (
    !cs_n && !$past(cs_n) && !$past(cs_n, 2) && $changed(dout)
      |-> !$past(sclk))
    else $error("serial output moved outside a falling edge");
  a_ready_after_reset: assert property (
    $rose(rst_n) |-> ##[1:4] ready)
    else $error("ready late after reset");
  a_ready_holds: assert property (
    ready |=> ready)
    else $error("ready dropped");
  a_index_clear: assert property (
    capture_done && ready |=> sample_index == 10'h000)
    else $error("sample index not cleared by capture done");
endmodule : vibration_sensor_spi_regs_asserts

bind vibration_sensor_spi_regs vibration_sensor_spi_regs_asserts i_asserts (
  .clk, .rst_n, .sclk, .cs_n, .din, .dout, .dout_oe, .capture_done,
  .sample_index, .capture_start, .nv_store, .command_pulse, .command_byte,
  .ready
);

// ==== verification/vibration_sensor_spi_regs_tb_top.sv ====
// Self-checking bench of the vibration sensor serial register block
module vibration_sensor_spi_regs_tb_top;
  import vibration_sensor_spi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] OFS [14] = '{7'h02, 7'h04, 7'h06, 7'h1c, 7'h1e,
    7'h20, 7'h22, 7'h24, 7'h26, 7'h28, 7'h32, 7'h34, 7'h36, 7'h38};
  localparam logic [6:0] FIXED [4] = '{7'h56, 7'h3e, 7'h08, 7'h43};
  logic clk, rst_n, sclk, cs_n, din, dout, dout_oe, ready;
  logic aux_digital_line_1_in, aux_digital_line_1_out, aux_digital_line_1_oe;
  logic aux_digital_line_2_in, aux_digital_line_2_out, aux_digital_line_2_oe;
  logic capture_busy, alarm_active, capture_done, capture_start;
  logic capture_trigger, nv_store, command_pulse;
  capture_results_t capture_results;
  sample_set_t sample_set;
  logic [15:0] flash_write_count, system_status, selftest_response, pend;
  cfg_image_t nv_image, config_words, shadow;
  logic [9:0] sample_index, idx;
  command_byte_t command_byte;
  logic [1:0] lv;
  int fails = 0, samples_checked = 0, starts = 0, stores = 0;

  vibration_sensor_spi_regs i_vibration_sensor_spi_regs (.clk, .rst_n,
    .sclk, .cs_n, .din, .dout, .dout_oe, .aux_digital_line_1_in,
    .aux_digital_line_1_out, .aux_digital_line_1_oe, .aux_digital_line_2_in,
    .aux_digital_line_2_out, .aux_digital_line_2_oe, .capture_busy,
    .alarm_active, .capture_done, .capture_results, .sample_set,
    .flash_write_count, .system_status, .selftest_response, .nv_image,
    .config_words, .sample_index, .capture_start, .capture_trigger,
    .nv_store, .command_pulse, .command_byte, .ready);
  spi_host_model i_spi_host_model (.clk, .dout, .dout_oe, .sclk, .cs_n,
    .din);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Storage behind the store pulse, and pulse counters
  always @(posedge clk) begin
    if (nv_store) nv_image <= config_words;
    if (capture_start) starts <= starts + 1;
    if (nv_store) stores <= stores + 1;
  end

  function automatic logic [15:0] rnd16();
    return 16'($urandom());
  endfunction : rnd16
  function automatic logic [15:0] expect_reg(input logic [6:0] a);
    for (int s = 0; s < 14; s++) if (OFS[s][6:1] == a[6:1]) return shadow[s];
    case ({a[6:1], 1'b0})
      7'h00: return flash_write_count;
      7'h0a: return capture_results.supply;
      7'h0c: return capture_results.temperature;
      7'h0e: return capture_results.accel_peak;
      7'h10: return capture_results.aux1_peak;
      7'h12: return capture_results.aux2_peak;
      7'h14: return sample_set.valid ? sample_set.accel : 16'h8000;
      7'h16: return sample_set.valid ? sample_set.aux1 : 16'h8000;
      7'h18: return sample_set.valid ? sample_set.aux2 : 16'h8000;
      7'h1a: return {6'h00, idx};
      7'h3c: return system_status;
      7'h40: return selftest_response;
      7'h52: return 16'h0101; // Arbitrary value
      7'h54: return 16'h0202; // Arbitrary value
      7'h56: return 16'h0a5a;
      7'h58: return 16'h0303; // Arbitrary value
      default: return 16'h0000;
    endcase
  endfunction : expect_reg
  function automatic logic [15:0] line_exp(input int f, input logic lvl);
    case (f)
      0: return {14'h0, 1'b1, capture_busy};
      1: return {14'h0, 1'b1, alarm_active};
      2: return {14'h0, 1'b1, lvl};
      default: return 16'h0000;
    endcase
  endfunction : line_exp

  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // One frame; its reply belongs to the request before it
  task automatic frame(input logic [15:0] tx, input bit keep = 1'b0);
    logic [15:0] rx;
    logic [6:0] a;
    a = tx[14:8];
    i_spi_host_model.xfer(tx, keep, rx);
    check("reply", rx, pend);
    pend = tx[15] ? 16'h0000 : expect_reg(a);
    if (tx[15]) begin
      for (int s = 0; s < 14; s++) begin
        if (OFS[s][6:1] == a[6:1] && a[0]) shadow[s][15:8] = tx[7:0];
        if (OFS[s][6:1] == a[6:1] && !a[0]) shadow[s][7:0] = tx[7:0];
      end
      if (a == 7'h1a) idx[7:0] = tx[7:0];
      if (a == 7'h1b) idx[9:8] = tx[1:0];
    end else if (a[6:1] inside {6'h0a, 6'h0b, 6'h0c}) begin
      idx = idx + 10'h001;
    end
    check("index", {6'h00, sample_index}, {6'h00, idx});
    for (int s = 0; s < 14; s++)
      check("config", config_words[s], shadow[s]);
  endtask : frame
  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    check("control reset", config_words[3], 16'h0020);
    check("misc reset", config_words[11], 16'h0003);
    check("line reset", config_words[12], 16'h000f);
    check("index reset", {6'h00, sample_index}, 16'h0000);
    rst_n = 1'b1;
    for (int i = 0; i < 10 && ready !== 1'b1; i++) @(negedge clk);
    check("ready", {15'h0, ready}, 16'h0001);
    if (ready !== 1'b1) test_done();
    shadow = nv_image;
    idx = 10'h000;
    pend = 16'h0000;
    for (int s = 0; s < 14; s++)
      check("loaded", config_words[s], shadow[s]);
    $display("test reset done");
  endtask : reset_dut

  initial begin
    logic [15:0] v;
    int s;
    void'($urandom(32'h3e55));
    rst_n = 1'b0;
    {aux_digital_line_1_in, aux_digital_line_2_in} = 2'b00;
    {capture_busy, alarm_active, capture_done} = 3'b000;
    capture_results = {rnd16(), rnd16(), rnd16(), rnd16(), rnd16()};
    sample_set = {1'b1, rnd16(), rnd16(), rnd16()};
    {flash_write_count, system_status, selftest_response} =
      {rnd16(), rnd16(), rnd16()};
    for (int i = 0; i < 14; i++) nv_image[i] = rnd16();
    reset_dut();
    for (int i = 0; i < 12; i++) frame({1'b0, 7'($urandom_range(0, 91)),
      8'($urandom())});
    frame({1'b1, 7'h56, 8'h00});
    foreach (FIXED[i]) frame({1'b0, FIXED[i], 8'h00});
    $display("test reads done");
    for (int i = 0; i < 3; i++) begin
      s = $urandom_range(0, 13);
      v = rnd16();
      frame({1'b1, OFS[s] + 7'h01, v[15:8]});
      frame({1'b1, OFS[s], v[7:0]});
      frame({1'b0, OFS[s], 8'h00});
    end
    $display("test writes done");
    frame(16'h9a38);
    frame(16'h9b01);
    repeat (3) frame(16'h1400, 1'b1);
    frame(16'h1a00);
    @(negedge clk);
    capture_done = 1'b1;
    @(negedge clk);
    capture_done = 1'b0;
    idx = 10'h000;
    @(negedge clk);
    check("cleared index", {6'h00, sample_index}, 16'h0000);
    sample_set.valid = 1'b0;
    frame(16'h1600);
    frame(16'h1a00);
    $display("test index done");
    frame(16'hbf08);
    check("starts", 16'(starts), 16'h0001);
    frame(16'hbf10);
    check("stores", 16'(stores), 16'h0001);
    check("command", {7'h00, command_byte}, {7'h00, 1'b1, 8'h10});
    reset_dut();
    frame({1'b1, 7'h32, 8'h03});
    lv = 2'($urandom());
    frame({1'b1, 7'h33, {6'h00, lv}});
    for (int f = 0; f < 4; f++) begin
      frame({1'b1, 7'h36, {4'h0, 2'(f), 2'(f)}});
      {aux_digital_line_1_in, aux_digital_line_2_in, capture_busy,
        alarm_active} = 4'($urandom());
      repeat (4) @(negedge clk);
      check("line one", {14'h0, aux_digital_line_1_oe, f == 3 ? 1'b0 :
        aux_digital_line_1_out}, line_exp(f, lv[0]));
      check("line two", {14'h0, aux_digital_line_2_oe, f == 3 ? 1'b0 :
        aux_digital_line_2_out}, line_exp(f, lv[1]));
      check("trigger", {15'h0, capture_trigger}, {15'h0, f == 3 &&
        (aux_digital_line_1_in || aux_digital_line_2_in)});
    end
    $display("test lines done");
    test_done();
  end
endmodule : vibration_sensor_spi_regs_tb_top
